// File: hw/dhb_pkg.sv
/*
  Shared constants for the host bus port of the dual serial channel device.
  Assumes one 100 MHz clock and a synchronous active-low reset.
*/
package dhb_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 4;
  // Device register map (index on the four select lines)
  localparam logic [3:0]  ADR_MODE      = 4'h0;
  localparam logic [3:0]  ADR_STAT_ONE  = 4'h1;
  localparam logic [3:0]  ADR_TEST      = 4'h2;
  localparam logic [3:0]  ADR_STAT_TWO  = 4'h3;
  localparam logic [3:0]  ADR_OUT_PORT_CONFIG_REG      = 4'h4;
  localparam logic [3:0]  ADR_IRQ_STAT  = 4'h5;
  localparam logic [3:0]  ADR_IRQ_MASK  = 4'h6;
  localparam logic [3:0]  ADR_OPR_SET   = 4'hE;
  localparam logic [3:0]  ADR_OPR_CLR   = 4'hF;
  localparam logic [3:0]  ADR_EVT       = 4'h8;
  localparam logic [3:0]  ADR_GPO_READ  = 4'hD;
  localparam logic [3:0]  ADR_CHAN_CTL  = 4'hA;
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [7:0]  RST_GPO       = 8'hFF;
  localparam logic        PTR_FIRST     = 1'b0;
  // Controller software registers
  localparam logic [2:0]  CR_ADDR       = 3'h0;
  localparam logic [2:0]  CR_WDATA      = 3'h1;
  localparam logic [2:0]  CR_CMD        = 3'h2;
  localparam logic [2:0]  CR_RDATA      = 3'h3;
  localparam logic [2:0]  CR_STAT       = 3'h4;
  localparam logic [2:0]  CR_EVT        = 3'h5;
  localparam logic [2:0]  CR_MASK       = 3'h6;
  localparam logic [7:0]  CMD_WRITE     = 8'h01;
  localparam logic [7:0]  CMD_READ      = 8'h02;
  // Host strobe phase lengths in ns, rounded up to whole cycles
  localparam int          SETUP_NS      = 20;
  localparam int          STROBE_NS     = 40;
  localparam int          CLK_NS        = 10;
  localparam logic [3:0]  SETUP_CYC     = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  STROBE_CYC    = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
endpackage

// File: hw/dhb_if.sv
/*
  Parallel host bus between processor side and device side.
  Assumes the bench resolves the shared data wire from the two enables.
*/
interface dhb_if;
  logic       chip_select_n;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic [3:0] reg_select_lines;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] host_data_bus;
  logic       irq_request_n_out;
  logic       irq_request_n_oe;
  logic       irq_request_n;
  modport device (
    input  chip_select_n, write_strobe_n, read_strobe_n, reg_select_lines,
    input  host_data_bus,
    output dev_data_out, dev_data_oe, irq_request_n_out, irq_request_n_oe
  );
  modport host (
    output chip_select_n, write_strobe_n, read_strobe_n, reg_select_lines,
    output host_data_out, host_data_oe,
    input  host_data_bus, irq_request_n
  );
endinterface

// File: hw/dhb_device.sv
/*
  Device end of the host bus: register file, reset behaviour, interrupt.
  Holds the device register map, the strobe edge capture, the read
  mux, the device reset and the open-drain interrupt request.
  Holds no transmitter or receiver engine; serial pins are stubs.
  Assumes bus pins are synchronous to clk_in; active-high device reset.
  Assumes the surrounding bench resolves the shared data wire and the
  open-drain request line from the enables driven here.
*/
// Decided for this implementation: the placing of the registers and the plain strobed port.
// Contract
// - Data lines float while chip select high
// - Write captured on write strobe rising edge
// - Selected read drives addressed register onto bus
// - Four select lines choose the register
// - Data bit zero is the least significant
// - Device reset clears status, mask, port registers
// - Reset drives general outputs high, stops timer
// - Reset idles channels, serial outputs at mark
// - Reset clears test modes, points at first mode
// - Request pulled low while unmasked condition holds
// - Receiver reads high as mark, low as space
// - Transmitter rests at mark when idle
module dhb_device
  import dhb_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       dev_reset_in,
  input  wire logic [7:0] chan_event_in,
  input  wire logic       chan_one_serial_in,
  input  wire logic       chan_two_serial_in,
  dhb_if.device           bus,
  output logic [7:0]      general_outputs_out,
  output logic            chan_one_serial_out,
  output logic            chan_two_serial_out,
  output logic            timer_run_out,
  output logic            mode_ptr_out,
  output logic [7:0]      test_mode_out
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    // Write capture: strobe seen last cycle and its address
    logic       wr_d;
    logic [3:0] wr_adr;
    // Device registers
    logic [7:0] chan_one_status_reg;
    logic [7:0] chan_two_status_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] out_port_value_reg;
    logic [7:0] out_port_config_reg;
    logic [7:0] test_mode;
    logic [7:0] chan_ctl;
    logic       mode_ptr;
    logic       timer_run;
    // Read data registered each cycle from the select lines
    logic [7:0] rd_data;
  } dhb_dev_s;

  dhb_dev_s   st;
  dhb_dev_s   next_st;
  logic       wr_act;
  logic       rd_act;
  logic       wr_commit;
  logic       irq_pending;
  logic [1:0] rx_space;
  logic [1:0] rx_line;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Strobes are dead while the chip is not selected
  assign wr_act = !bus.chip_select_n && !bus.write_strobe_n;
  assign rd_act = !bus.chip_select_n && !bus.read_strobe_n;
  // Strobe rising edge: active last cycle, released now
  assign wr_commit = st.wr_d && !wr_act;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_st = st;
    next_st.wr_d = wr_act;
    if (wr_act)
    begin
      next_st.wr_adr = bus.reg_select_lines;
    end
    // Events set sticky; set wins over a clear in the same cycle
    // Capture on the strobe's rising edge, address held
    if (wr_commit)
    begin
      case (st.wr_adr)
        ADR_MODE:      next_st.mode_ptr = 1'b1;
        ADR_TEST:      next_st.test_mode = bus.host_data_bus;
        ADR_OUT_PORT_CONFIG_REG:      next_st.out_port_config_reg = bus.host_data_bus;
        ADR_IRQ_MASK:  next_st.irq_mask_reg = bus.host_data_bus;
        ADR_IRQ_STAT:  next_st.irq_status_reg =
                         st.irq_status_reg & ~bus.host_data_bus;
        ADR_CHAN_CTL:
        begin
          next_st.chan_ctl = bus.host_data_bus;
          next_st.timer_run = bus.host_data_bus[7];
        end
        ADR_OPR_SET:   next_st.out_port_value_reg =
                         st.out_port_value_reg | bus.host_data_bus;
        ADR_OPR_CLR:   next_st.out_port_value_reg =
                         st.out_port_value_reg & ~bus.host_data_bus;
        // Other addresses are read only or unused
        default:       next_st.mode_ptr = st.mode_ptr;
      endcase
    end

    next_st.irq_status_reg = next_st.irq_status_reg | chan_event_in;
    next_st.chan_one_status_reg = st.chan_one_status_reg
                                  | {7'h00, rx_space[0]};
    next_st.chan_two_status_reg = st.chan_two_status_reg
                                  | {7'h00, rx_space[1]};

    // D0 is bit zero of every value
    case (bus.reg_select_lines)
      ADR_MODE:      next_st.rd_data = {7'h00, st.mode_ptr};
      ADR_STAT_ONE:  next_st.rd_data = st.chan_one_status_reg;
      ADR_STAT_TWO:  next_st.rd_data = st.chan_two_status_reg;
      ADR_TEST:      next_st.rd_data = st.test_mode;
      ADR_OUT_PORT_CONFIG_REG:      next_st.rd_data = st.out_port_config_reg;
      ADR_IRQ_STAT:  next_st.rd_data = st.irq_status_reg;
      ADR_IRQ_MASK:  next_st.rd_data = st.irq_mask_reg;
      ADR_CHAN_CTL:  next_st.rd_data = st.chan_ctl;
      ADR_GPO_READ:  next_st.rd_data = st.out_port_value_reg;
      default:       next_st.rd_data = RST_ZERO;
    endcase

    // Device reset clears registers and parks everything
    if (dev_reset_in)
    begin
      next_st.chan_one_status_reg = RST_ZERO;
      next_st.chan_two_status_reg = RST_ZERO;
      next_st.irq_mask_reg        = RST_ZERO;
      next_st.irq_status_reg      = RST_ZERO;
      next_st.out_port_value_reg  = RST_ZERO;
      next_st.out_port_config_reg = RST_ZERO;
      next_st.test_mode           = RST_ZERO;
      next_st.chan_ctl            = RST_ZERO;
      next_st.mode_ptr            = PTR_FIRST;
      next_st.timer_run           = 1'b0;
      next_st.wr_d                = 1'b0;
    end
  end

  // ****************************************************************
  // Serial inputs
  // ****************************************************************
  // Serial input: high is mark, low is space, bit 0 first
  assign rx_line = {chan_two_serial_in, chan_one_serial_in};
  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_rx
      assign rx_space[ch] = !rx_line[ch] && st.chan_ctl[ch];
    end
  endgenerate

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    // Bench reset zeroes all; device reset is handled above
    if (!rst_n_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Data lines float unless a selected read is in progress
  assign bus.dev_data_out = st.rd_data;
  assign bus.dev_data_oe  = rd_act;

  // Open drain: drive low only when an unmasked condition holds
  assign irq_pending = |(st.irq_status_reg & st.irq_mask_reg);
  assign bus.irq_request_n_out = 1'b0;
  assign bus.irq_request_n_oe  = irq_pending;

  // Outputs are inverted register bits, so reset shows all high
  assign general_outputs_out = ~st.out_port_value_reg;
  // Timer stops at once while reset is high, not a cycle later
  assign timer_run_out = st.timer_run && !dev_reset_in;

  // No transmitter engine here; lines rest at mark
  assign chan_one_serial_out = 1'b1;
  assign chan_two_serial_out = 1'b1;
  assign mode_ptr_out  = st.mode_ptr;
  assign test_mode_out = st.test_mode;
endmodule

// File: hw/dhb_host.sv
/*
  Processor end of the host bus, driven from a small software port.
  Assumes the device end captures on the write strobe's rising edge.
*/
module dhb_host
  import dhb_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] sw_addr_in,
  input  wire logic [7:0] sw_wdata_in,
  input  wire logic       sw_write_in,
  input  wire logic       sw_read_in,
  output logic [7:0]      sw_rdata_out,
  output logic            irq_out,
  dhb_if.host             bus
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SETUP = 2'b01,
    HS_STRB  = 2'b10,
    HS_HOLD  = 2'b11
  } dhb_hst_e;

  typedef struct packed {
    dhb_hst_e   fsm;
    logic [3:0] cnt;
    logic       is_rd;
    logic [3:0] adr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic       busy;
    logic [1:0] evt;
    logic [1:0] mask;
    logic [7:0] sw_rd;
  } dhb_hst_s;

  dhb_hst_s st;
  dhb_hst_s next_st;
  logic     done;

  always_comb
  begin
    next_st = st;
    done = 1'b0;
    case (st.fsm)
      HS_IDLE: next_st.cnt = 4'h0;
      HS_SETUP:
      begin
        next_st.cnt = st.cnt + 4'h1;
        if (st.cnt + 4'h1 >= SETUP_CYC)
        begin
          next_st.fsm = HS_STRB;
          next_st.cnt = 4'h0;
        end
      end
      HS_STRB:
      begin
        next_st.cnt = st.cnt + 4'h1;
        if (st.cnt + 4'h1 >= STROBE_CYC)
        begin
          next_st.fsm = HS_HOLD;
          if (st.is_rd)
          begin
            next_st.rdat = bus.host_data_bus;
          end
        end
      end
      HS_HOLD:
      begin
        next_st.fsm = HS_IDLE;
        next_st.busy = 1'b0;
        done = 1'b1;
      end
      default: next_st.fsm = HS_IDLE;
    endcase
    if (sw_write_in)
    begin
      case (sw_addr_in)
        CR_ADDR:  next_st.adr = sw_wdata_in[3:0];
        CR_WDATA: next_st.wdat = sw_wdata_in;
        CR_CMD:
          if (st.fsm == HS_IDLE && sw_wdata_in != RST_ZERO)
          begin
            next_st.fsm   = HS_SETUP;
            next_st.busy  = 1'b1;
            next_st.is_rd = (sw_wdata_in == CMD_READ);
          end
        CR_EVT:   next_st.evt = st.evt & ~sw_wdata_in[1:0];
        CR_MASK:  next_st.mask = sw_wdata_in[1:0];
        default:  next_st.adr = st.adr;
      endcase
    end
    // Event bits: 0 access done, 1 device irq; set wins over clear
    next_st.evt = next_st.evt | {!bus.irq_request_n, done};
    case (sw_addr_in)
      CR_ADDR:  next_st.sw_rd = {4'h0, st.adr};
      CR_WDATA: next_st.sw_rd = st.wdat;
      CR_RDATA: next_st.sw_rd = st.rdat;
      CR_STAT:  next_st.sw_rd = {7'h00, st.busy};
      CR_EVT:   next_st.sw_rd = {6'h00, st.evt};
      CR_MASK:  next_st.sw_rd = {6'h00, st.mask};
      default:  next_st.sw_rd = RST_ZERO;
    endcase
    if (!sw_read_in)
    begin
      next_st.sw_rd = st.sw_rd;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Select spans setup to hold so strobes only act inside it
  assign bus.chip_select_n    = (st.fsm == HS_IDLE);
  assign bus.reg_select_lines = st.adr;
  // Only one strobe per access; write releases before hold
  assign bus.write_strobe_n   = !(st.fsm == HS_STRB && !st.is_rd);
  assign bus.read_strobe_n    = !(st.fsm == HS_STRB && st.is_rd);
  assign bus.host_data_out    = st.wdat;
  assign bus.host_data_oe     = !st.is_rd && st.fsm != HS_IDLE;
  assign sw_rdata_out = st.sw_rd;
  assign irq_out      = |(st.evt & st.mask);
endmodule

// File: bench/dhb_monitor.sv
/*
  Checker for the host bus wires joining the two ends.
  Assumes the bench instantiates it beside the interface.
*/
module dhb_monitor (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       chip_select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [3:0] reg_select_lines,
  input  wire logic [7:0] host_data_bus,
  input  wire logic       dev_data_oe
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_hiz;
    chip_select_n |-> !dev_data_oe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("data driven while unselected");
  property p_rd_drive;
    !chip_select_n && !read_strobe_n |-> dev_data_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read data not driven");
  property p_wr_quiet;
    !write_strobe_n |-> !dev_data_oe;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("device drives during write");
  property p_one_strobe;
    !(!read_strobe_n && !write_strobe_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("both strobes low");
  property p_strobe_sel;
    !read_strobe_n || !write_strobe_n |-> !chip_select_n;
  endproperty
  a_strobe_sel: assert property (p_strobe_sel)
    else $error("strobe outside select");
  property p_wr_len;
    $fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write strobe length wrong");
  property p_setup;
    $fell(chip_select_n) |-> (read_strobe_n && write_strobe_n) [*2]
      ##1 (!read_strobe_n || !write_strobe_n);
  endproperty
  a_setup: assert property (p_setup)
    else $error("strobe setup wrong");
  property p_addr_hold;
    !chip_select_n && $past(!chip_select_n) |-> $stable(reg_select_lines);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved in access");
  property p_data_hold;
    !write_strobe_n && $past(!write_strobe_n) |-> $stable(host_data_bus);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data moved");
  property p_rd_end;
    $rose(read_strobe_n) |-> !dev_data_oe;
  endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("data held past read");
endmodule

// File: bench/duart_host_bus_and_reset_tb.sv
/*
  Bench: processor end facing device end over the host bus.
  Assumes nothing outside; resolves the shared wires itself.
*/
module duart_host_bus_and_reset_tb
  import dhb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in, rst_n_in, dev_reset_in, ser_one, ser_two;
  logic [7:0] chan_event_in, sw_wdata, sw_rdata, gpo, test_mode;
  logic [2:0] sw_addr;
  logic       sw_write, sw_read, irq_out, tx_one, tx_two, run, ptr;
  int         bad_count, tests_run, cycles;
  dhb_if      bus ();
  // Undriven bus floats high, as with pull-ups
  assign bus.host_data_bus = bus.dev_data_oe ? bus.dev_data_out :
                             bus.host_data_oe ? bus.host_data_out : 8'hFF;
  assign bus.irq_request_n = bus.irq_request_n_oe ? 1'b0 : 1'b1;
  dhb_host dhb_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_write_in(sw_write),
    .sw_read_in(sw_read), .sw_rdata_out(sw_rdata), .irq_out(irq_out),
    .bus(bus));
  dhb_device dhb_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .dev_reset_in(dev_reset_in), .chan_event_in(chan_event_in),
    .chan_one_serial_in(ser_one), .chan_two_serial_in(ser_two), .bus(bus),
    .general_outputs_out(gpo), .chan_one_serial_out(tx_one),
    .chan_two_serial_out(tx_two), .timer_run_out(run),
    .mode_ptr_out(ptr), .test_mode_out(test_mode));
  dhb_monitor dhb_monitor_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .chip_select_n(bus.chip_select_n), .write_strobe_n(bus.write_strobe_n),
    .read_strobe_n(bus.read_strobe_n),
    .reg_select_lines(bus.reg_select_lines),
    .host_data_bus(bus.host_data_bus), .dev_data_oe(bus.dev_data_oe));
  /****************/
  /* Shared tasks */
  /****************/
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge clk_in);
    sw_write <= 1'b0;
  endtask
  task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge clk_in);
    sw_read <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // Polls busy under a bound; a hung access counts as a mismatch
  task automatic dev_op(input logic [7:0] cmd, input logic [3:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    int n;
    sw_wr(CR_ADDR, {4'h0, a});
    sw_wr(CR_WDATA, d);
    sw_wr(CR_CMD, cmd);
    n = 0;
    do
    begin
      sw_rd(CR_STAT, q);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    check("busy", {7'h00, q[0]}, 8'h00);
    sw_rd(CR_RDATA, q);
  endtask
  /*********/
  /* Tests */
  /*********/
  task automatic t_reset();
    logic [7:0] q;
    logic [3:0] regs [5] = '{ADR_STAT_ONE, ADR_STAT_TWO, ADR_IRQ_MASK,
                             ADR_IRQ_STAT, ADR_OUT_PORT_CONFIG_REG};
    check("gpo", gpo, RST_GPO);
    check("timer", run, 8'h00);
    check("tx one", tx_one, 8'h01);
    check("tx two", tx_two, 8'h01);
    check("ptr", ptr, PTR_FIRST);
    check("test", test_mode, RST_ZERO);
    foreach (regs[i])
    begin
      dev_op(CMD_READ, regs[i], 8'h00, q);
      check("reset reg", q, RST_ZERO);
    end
    $display("reset test done");
  endtask
  task automatic t_rw();
    logic [7:0] q;
    dev_op(CMD_WRITE, ADR_IRQ_MASK, 8'hA5, q);
    dev_op(CMD_WRITE, ADR_OUT_PORT_CONFIG_REG, 8'h5A, q);
    dev_op(CMD_READ, ADR_IRQ_MASK, 8'h00, q);
    check("mask", q, 8'hA5);
    dev_op(CMD_READ, ADR_OUT_PORT_CONFIG_REG, 8'h00, q);
    check("out_port_config_reg", q, 8'h5A);
    dev_op(CMD_WRITE, ADR_IRQ_MASK, 8'h00, q);
    dev_op(CMD_WRITE, ADR_OPR_SET, 8'h01, q);
    check("gpo bit0", gpo, 8'hFE);
    dev_op(CMD_WRITE, ADR_OPR_CLR, 8'h01, q);
    check("gpo clr", gpo, 8'hFF);
    $display("write read test done");
  endtask
  task automatic t_irq();
    logic [7:0] q;
    @(posedge clk_in);
    chan_event_in <= 8'h04;
    @(posedge clk_in);
    chan_event_in <= 8'h00;
    dev_op(CMD_READ, ADR_IRQ_STAT, 8'h00, q);
    check("irq stat", q, 8'h04);
    check("irq masked", bus.irq_request_n, 8'h01);
    dev_op(CMD_WRITE, ADR_IRQ_MASK, 8'h04, q);
    check("irq low", bus.irq_request_n, 8'h00);
    sw_wr(CR_MASK, 8'h02);
    #1 check("host irq", irq_out, 8'h01);
    dev_op(CMD_WRITE, ADR_IRQ_STAT, 8'h04, q);
    check("irq freed", bus.irq_request_n, 8'h01);
    sw_wr(CR_EVT, 8'h03);
    #1 check("host irq off", irq_out, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic t_serial();
    logic [7:0] q;
    dev_op(CMD_WRITE, ADR_CHAN_CTL, 8'h01, q);
    @(posedge clk_in);
    ser_one <= 1'b0;
    repeat (2) @(posedge clk_in);
    ser_one <= 1'b1;
    dev_op(CMD_READ, ADR_STAT_ONE, 8'h00, q);
    check("space seen", q[0], 8'h01);
    dev_op(CMD_READ, ADR_STAT_TWO, 8'h00, q);
    check("idle chan", q[0], 8'h00);
    check("tx mark", tx_one, 8'h01);
    $display("serial test done");
  endtask
  task automatic t_dev_reset();
    logic [7:0] q;
    dev_op(CMD_WRITE, ADR_OPR_SET, 8'hF0, q);
    dev_op(CMD_WRITE, ADR_TEST, 8'h01, q);
    dev_op(CMD_WRITE, ADR_MODE, 8'h00, q);
    dev_op(CMD_WRITE, ADR_CHAN_CTL, 8'h80, q);
    check("timer on", run, 8'h01);
    check("gpo set", gpo, 8'h0F);
    check("ptr set", ptr, 8'h01);
    check("test set", test_mode, 8'h01);
    @(posedge clk_in);
    dev_reset_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    dev_reset_in <= 1'b0;
    #1 check("gpo", gpo, RST_GPO);
    check("timer off", run, 8'h00);
    check("test off", test_mode, RST_ZERO);
    check("ptr", ptr, PTR_FIRST);
    dev_op(CMD_READ, ADR_STAT_ONE, 8'h00, q);
    check("stat clr", q, RST_ZERO);
    dev_op(CMD_READ, ADR_IRQ_MASK, 8'h00, q);
    check("mask clr", q, RST_ZERO);
    $display("device reset test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Tests need a few hundred cycles; the ceiling leaves ample room
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  initial
  begin
    {rst_n_in, dev_reset_in, sw_write, sw_read} = 4'h0;
    {ser_one, ser_two, cycles, bad_count, tests_run} = '1;
    {cycles, bad_count, tests_run} = '0;
    {chan_event_in, sw_wdata, sw_addr} = '0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_rw();
    t_irq();
    t_serial();
    t_dev_reset();
    conclude();
  end
endmodule
